// ### shared/csp_pkg.sv
// constants and types of the configurable serial port
package csp_pkg;
    localparam int          CLK_HZ     = 100_000_000;
    localparam int          OVERSAMPLE = 16;
    localparam logic [3:0]  TICK_LAST  = 4'hf;
    localparam logic [3:0]  HALF_LAST  = 4'h7;

    localparam logic [7:0]  ADR_CFG  = 8'h00;
    localparam logic [7:0]  ADR_CTRL = 8'h04;
    localparam logic [7:0]  ADR_STAT = 8'h08;
    localparam logic [7:0]  ADR_TXD  = 8'h0c;
    localparam logic [7:0]  ADR_RXD  = 8'h10;

    localparam int          CTRL_REQ  = 0;
    localparam int          STAT_DONE = 0;
    localparam int          STAT_FAIL = 1;
    localparam int          STAT_TERM = 2;
    localparam int          STAT_PERR = 3;
    localparam int          STAT_FERR = 4;
    localparam int          STAT_OVR  = 5;
    localparam int          STAT_HOLD = 6;
    localparam int          STAT_ERR  = 8;
    localparam int          RXD_VALID = 8;
    localparam int          CFG_W     = 23;

    localparam logic [7:0]  XON  = 8'h11;
    localparam logic [7:0]  XOFF = 8'h13;

    localparam logic [2:0]  RATE_110  = 3'h0;
    localparam logic [2:0]  RATE_9600 = 3'h6;
    localparam logic [3:0]  BAUD_MAX  = 4'h8;
    localparam logic [1:0]  CODE_BAD  = 2'h3;
    localparam logic [2:0]  FLOW_MAX  = 3'h4;

    localparam logic [3:0]  ERR_NONE   = 4'h0;
    localparam logic [3:0]  ERR_BAUD   = 4'h1;
    localparam logic [3:0]  ERR_PARITY = 4'h2;
    localparam logic [3:0]  ERR_DBITS  = 4'h3;
    localparam logic [3:0]  ERR_STOP   = 4'h4;
    localparam logic [3:0]  ERR_FLOW   = 4'h5;
    localparam logic [3:0]  ERR_RATE   = 4'h6;

    typedef enum logic [2:0] {
        FL_NONE = 3'h0, FL_SEND = 3'h1, FL_RECV = 3'h2,
        FL_BOTH = 3'h3, FL_HW = 3'h4
    } csp_flow_t;
    typedef enum logic [1:0] {
        PAR_NONE = 2'h0, PAR_EVEN = 2'h1, PAR_ODD = 2'h2
    } csp_par_t;
    typedef enum logic [1:0] {
        TX_IDLE = 2'h0, TX_START = 2'h1, TX_DATA = 2'h2, TX_STOP = 2'h3
    } csp_tx_st_t;
    typedef enum logic [1:0] {
        RX_IDLE = 2'h0, RX_START = 2'h1, RX_DATA = 2'h2, RX_STOP = 2'h3
    } csp_rx_st_t;

    // software view of the line_config register, lsb first: baud
    typedef struct packed {
        logic [7:0] term;
        logic       term_en;
        logic       txdis;
        logic [2:0] flow;
        logic [1:0] stop;
        logic [1:0] dbits;
        logic [1:0] parity;
        logic [3:0] baud;
    } csp_cfg_t;

    // resolved line setting in force
    typedef struct packed {
        logic [7:0] term;
        logic       term_en;
        logic       txdis;
        csp_flow_t  flow;
        logic       two_stop;
        logic       seven;
        csp_par_t   par;
        logic [2:0] rate;
    } csp_line_t;

    localparam csp_line_t LINE_DEFAULT = '{term: 8'h00, term_en: 1'b0,
        txdis: 1'b0, flow: FL_NONE, two_stop: 1'b0, seven: 1'b0,
        par: PAR_NONE, rate: RATE_9600};

    function automatic int csp_bps(input logic [2:0] r);
        case (r)
            3'h0: csp_bps = 110;
            3'h1: csp_bps = 300;
            3'h2: csp_bps = 600;
            3'h3: csp_bps = 1200;
            3'h4: csp_bps = 2400;
            3'h5: csp_bps = 4800;
            3'h6: csp_bps = 9600;
            default: csp_bps = 19200;
        endcase
    endfunction : csp_bps
endpackage : csp_pkg

// ### verilog/csp_fifo2.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module csp_fifo2 #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    import csp_pkg::*;
    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic              wp;
        logic              rp;
        logic [1:0]        cnt;
    } csp_fifo_st_t;
    csp_fifo_st_t st_r;
    csp_fifo_st_t st_nxt;
    logic         push;
    logic         pop;

    assign in_ready  = (st_r.cnt != 2'h2);
    assign out_valid = (st_r.cnt != 2'h0);
    assign out_data  = st_r.mem[st_r.rp];

    always_comb begin
        st_nxt = st_r;
        push   = in_valid & in_ready;
        pop    = out_valid & out_ready;
        if (push) begin
            st_nxt.mem[st_r.wp] = in_data;
            st_nxt.wp = ~st_r.wp;
        end
        if (pop) begin
            st_nxt.rp = ~st_r.rp;
        end
        case ({push, pop})
            2'b10:   st_nxt.cnt = st_r.cnt + 2'h1;
            2'b01:   st_nxt.cnt = st_r.cnt - 2'h1;
            default: st_nxt.cnt = st_r.cnt;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule : csp_fifo2
`default_nettype wire

// ### verilog/csp_baud.sv
// sixteen-times bit rate enable from the system clock
`timescale 1ns/1ps
`default_nettype none
module csp_baud #(
    parameter int CLK_HZ = csp_pkg::CLK_HZ
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [2:0] rate,
    output logic            tick
);
    import csp_pkg::*;
    typedef struct packed {
        logic [16:0] cnt;
        logic        tick;
    } csp_baud_st_t;
    csp_baud_st_t st_r;
    csp_baud_st_t st_nxt;
    logic [16:0]  div;
    int           bps;

    assign tick = st_r.tick;

    always_comb begin
        bps = csp_bps(rate);
        div = 17'((CLK_HZ + bps * 8) / (bps * OVERSAMPLE));
        if (div == 17'h0) begin
            div = 17'h1;
        end
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (st_r.cnt >= div - 17'h1) begin
            st_nxt.cnt  = 17'h0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 17'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule : csp_baud
`default_nettype wire

// ### verilog/csp_top.sv
// configurable serial port with wishbone register access
// Notes on behaviour
// - eight bit rates from 110 to 19200 bit/s chosen by configuration.
// - rates above 9600 only accepted together with hardware handshake.
// - even parity sets parity bit when data holds odd ones; none skips.
// - odd parity sets parity bit when data holds even number of ones.
// - seven or eight data bits; eight when unspecified.
// - one or two idle stop bit times after every character.
// - defaults 9600, no parity, 8 bits, no flow, 1 stop; 110 uses 2.
// - flow setting is none, send, receive, both software, or hardware.
// - receive-side software: XOFF received halts sending, XON resumes.
// - send-side software: send XOFF when receive path fills, XON after.
// - hardware mode throttles with RTS and CTS; send only while CTS on.
// - transmitter-disable option turns driver off when nothing pending.
// - optional terminator character flags end of a data block.
// - configuration applied on rising edge of single-cycle request.
// - success gives zero code and done; invalid gives code and fail.
`timescale 1ns/1ps
`default_nettype none
module csp_top #(
    parameter int CLK_HZ = csp_pkg::CLK_HZ
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        rxd,
    input  wire logic        cts_n,
    output logic             txd,
    output logic             tx_oe,
    output logic             rts_n
);
    import csp_pkg::*;

    typedef struct packed {
        csp_cfg_t    cfg_r;
        csp_line_t   line;
        logic        req;
        logic        req_d;
        logic        done;
        logic        fail;
        logic [3:0]  err;
        logic        term_s;
        logic        perr_s;
        logic        ferr_s;
        logic        ovr_s;
        logic        hold;
        logic        xoff_sent;
        logic        ack;
        logic [31:0] rdat;
        csp_tx_st_t  tx_st;
        logic [3:0]  tx_tk;
        logic [3:0]  tx_cnt;
        logic [8:0]  tx_sh;
        logic        txd;
        logic        oe;
        csp_rx_st_t  rx_st;
        logic [3:0]  rx_tk;
        logic [3:0]  rx_cnt;
        logic [8:0]  rx_sh;
        logic        pv;
        logic [7:0]  pd;
    } csp_top_st_t;

    localparam csp_top_st_t ST_RST = '{line: LINE_DEFAULT, tx_st: TX_IDLE,
        rx_st: RX_IDLE, txd: 1'b1, oe: 1'b1, default: '0};

    logic [1:0]  rsync_r;
    logic        rst_s_n;
    csp_top_st_t st_r;
    csp_top_st_t n;
    logic        tick;
    logic        tx_in_ready;
    logic        tx_out_valid;
    logic        tx_pop;
    logic [7:0]  tx_out_data;
    logic        rx_in_ready;
    logic        rx_out_valid;
    logic        rx_pop;
    logic [7:0]  rx_out_data;
    logic        hit;
    logic        tx_wr;
    logic [31:0] cfg_word;
    logic [31:0] stat_word;
    logic [3:0]  e;
    logic        send_sw;
    logic        recv_sw;
    logic [3:0]  nb;
    logic        ch_ok;
    logic [7:0]  ch;
    logic [8:0]  al;
    logic [7:0]  rd_d;
    logic        rd_p;

    function automatic csp_line_t cfg_line(input csp_cfg_t c);
        csp_line_t l;
        l = LINE_DEFAULT;
        l.rate = (c.baud == 4'h0) ? RATE_9600 : 3'(c.baud - 4'h1);
        case (c.parity)
            2'h1:    l.par = PAR_EVEN;
            2'h2:    l.par = PAR_ODD;
            default: l.par = PAR_NONE;
        endcase
        l.seven    = (c.dbits == 2'h1);
        l.two_stop = (c.stop == 2'h2) ||
                     ((c.stop == 2'h0) && (l.rate == RATE_110));
        l.flow     = csp_flow_t'(c.flow);
        l.txdis    = c.txdis;
        l.term_en  = c.term_en;
        l.term     = c.term;
        return l;
    endfunction : cfg_line

    function automatic logic [3:0] cfg_err(input csp_cfg_t c);
        csp_line_t l;
        l = cfg_line(c);
        if (c.baud > BAUD_MAX) begin
            return ERR_BAUD;
        end else if (c.parity == CODE_BAD) begin
            return ERR_PARITY;
        end else if (c.dbits == CODE_BAD) begin
            return ERR_DBITS;
        end else if (c.stop == CODE_BAD) begin
            return ERR_STOP;
        end else if (c.flow > FLOW_MAX) begin
            return ERR_FLOW;
        end else if ((l.rate > RATE_9600) && (l.flow != FL_HW)) begin
            return ERR_RATE;
        end
        return ERR_NONE;
    endfunction : cfg_err

    function automatic logic [3:0] n_bits(input csp_line_t l);
        return (l.seven ? 4'h7 : 4'h8) + ((l.par != PAR_NONE) ? 4'h1 : 4'h0);
    endfunction : n_bits

    function automatic logic [8:0] frame(input logic [7:0] c,
                                         input csp_line_t l);
        logic [7:0] d;
        logic       p;
        d = l.seven ? {1'b0, c[6:0]} : c;
        p = (l.par == PAR_EVEN) ? (^d) : ~(^d);
        return l.seven ? {1'b0, p, d[6:0]} : {p, d};
    endfunction : frame

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsync_r <= 2'h0;
        end else begin
            rsync_r <= {rsync_r[0], 1'b1};
        end
    end
    assign rst_s_n = rsync_r[1];

    csp_baud #(.CLK_HZ(CLK_HZ)) u_baud (
        .clk   (ref_clk),
        .rst_n (rst_s_n),
        .rate  (st_r.line.rate),
        .tick  (tick)
    );

    csp_fifo2 #(.W(8)) u_txbuf (
        .clk       (ref_clk),
        .rst_n     (rst_s_n),
        .in_valid  (tx_wr),
        .in_ready  (tx_in_ready),
        .in_data   (wb_dat_i[7:0]),
        .out_valid (tx_out_valid),
        .out_ready (tx_pop),
        .out_data  (tx_out_data)
    );

    csp_fifo2 #(.W(8)) u_rxbuf (
        .clk       (ref_clk),
        .rst_n     (rst_s_n),
        .in_valid  (st_r.pv),
        .in_ready  (rx_in_ready),
        .in_data   (st_r.pd),
        .out_valid (rx_out_valid),
        .out_ready (rx_pop),
        .out_data  (rx_out_data)
    );

    assign wb_dat_o = st_r.rdat;
    assign wb_ack_o = st_r.ack;
    assign txd      = st_r.txd;
    assign tx_oe    = st_r.oe;
    assign rts_n    = (st_r.line.flow == FL_HW) ? ~rx_in_ready : 1'b0;

    always_comb begin
        n         = st_r;
        ch_ok     = 1'b0;
        ch        = 8'h00;
        al        = 9'h000;
        rd_d      = 8'h00;
        rd_p      = 1'b0;
        e         = ERR_NONE;
        tx_pop    = 1'b0;
        send_sw   = (st_r.line.flow == FL_SEND) || (st_r.line.flow == FL_BOTH);
        recv_sw   = (st_r.line.flow == FL_RECV) || (st_r.line.flow == FL_BOTH);
        nb        = n_bits(st_r.line);
        stat_word = 32'h0;
        stat_word[STAT_DONE]     = st_r.done;
        stat_word[STAT_FAIL]     = st_r.fail;
        stat_word[STAT_TERM]     = st_r.term_s;
        stat_word[STAT_PERR]     = st_r.perr_s;
        stat_word[STAT_FERR]     = st_r.ferr_s;
        stat_word[STAT_OVR]      = st_r.ovr_s;
        stat_word[STAT_HOLD]     = st_r.hold;
        stat_word[STAT_ERR +: 4] = st_r.err;
        cfg_word  = {9'h000, st_r.cfg_r};

        // bus slave; a transmit write waits while the buffer is full
        hit    = wb_cyc_i & wb_stb_i & ~st_r.ack;
        tx_wr  = hit & wb_we_i & (wb_adr_i == ADR_TXD);
        n.ack  = hit & ~(tx_wr & ~tx_in_ready);
        rx_pop = n.ack & ~wb_we_i & (wb_adr_i == ADR_RXD);
        n.req  = 1'b0;
        if (n.ack && wb_we_i) begin
            case (wb_adr_i)
                ADR_CFG: begin
                    for (int i = 0; i < 4; i++) begin
                        if (wb_sel_i[i]) begin
                            cfg_word[8*i +: 8] = wb_dat_i[8*i +: 8];
                        end
                    end
                    n.cfg_r = csp_cfg_t'(cfg_word[CFG_W-1:0]);
                end
                ADR_CTRL: n.req = wb_sel_i[0] & wb_dat_i[CTRL_REQ];
                ADR_STAT: begin
                    if (wb_sel_i[0]) begin
                        n.term_s = st_r.term_s & ~wb_dat_i[STAT_TERM];
                        n.perr_s = st_r.perr_s & ~wb_dat_i[STAT_PERR];
                        n.ferr_s = st_r.ferr_s & ~wb_dat_i[STAT_FERR];
                        n.ovr_s  = st_r.ovr_s & ~wb_dat_i[STAT_OVR];
                    end
                end
                default: ;
            endcase
        end
        if (n.ack && !wb_we_i) begin
            case (wb_adr_i)
                ADR_CFG:  n.rdat = {9'h000, st_r.cfg_r};
                ADR_STAT: n.rdat = stat_word;
                ADR_RXD:  n.rdat = {23'h0, rx_out_valid, rx_out_data};
                default:  n.rdat = 32'h0;
            endcase
        end

        // configuration request
        n.req_d = st_r.req;
        if (st_r.req && !st_r.req_d) begin
            e      = cfg_err(st_r.cfg_r);
            n.err  = e;
            n.done = (e == ERR_NONE);
            n.fail = (e != ERR_NONE);
            if (e == ERR_NONE) begin
                n.line = cfg_line(st_r.cfg_r);
            end
        end

        // transmitter
        if (!send_sw) begin
            n.xoff_sent = 1'b0;
        end
        case (st_r.tx_st)
            TX_IDLE: begin
                if (tick) begin
                    if (send_sw && !rx_in_ready && !st_r.xoff_sent) begin
                        ch          = XOFF;
                        ch_ok       = 1'b1;
                        n.xoff_sent = 1'b1;
                    end else if (send_sw && st_r.xoff_sent && !rx_out_valid) begin
                        ch          = XON;
                        ch_ok       = 1'b1;
                        n.xoff_sent = 1'b0;
                    end else if (tx_out_valid && !(recv_sw && st_r.hold) &&
                                 !((st_r.line.flow == FL_HW) && cts_n)) begin
                        ch     = tx_out_data;
                        ch_ok  = 1'b1;
                        tx_pop = 1'b1;
                    end
                    if (ch_ok) begin
                        n.tx_sh  = frame(ch, st_r.line);
                        n.tx_cnt = nb - 4'h1;
                        n.tx_tk  = 4'h0;
                        n.txd    = 1'b0;
                        n.tx_st  = TX_START;
                    end
                end
            end
            TX_START, TX_DATA, TX_STOP: begin
                if (tick && st_r.tx_tk != TICK_LAST) begin
                    n.tx_tk = st_r.tx_tk + 4'h1;
                end else if (tick) begin
                    n.tx_tk = 4'h0;
                    if (st_r.tx_st == TX_START) begin
                        n.txd   = st_r.tx_sh[0];
                        n.tx_sh = st_r.tx_sh >> 1;
                        n.tx_st = TX_DATA;
                    end else if (st_r.tx_st == TX_DATA && st_r.tx_cnt == 4'h0) begin
                        n.txd    = 1'b1;
                        n.tx_cnt = st_r.line.two_stop ? 4'h1 : 4'h0;
                        n.tx_st  = TX_STOP;
                    end else if (st_r.tx_st == TX_DATA) begin
                        n.txd    = st_r.tx_sh[0];
                        n.tx_sh  = st_r.tx_sh >> 1;
                        n.tx_cnt = st_r.tx_cnt - 4'h1;
                    end else if (st_r.tx_cnt == 4'h0) begin
                        n.tx_st = TX_IDLE;
                    end else begin
                        n.tx_cnt = st_r.tx_cnt - 4'h1;
                    end
                end
            end
            default: begin
                n.tx_st = TX_IDLE;
                n.txd   = 1'b1;
            end
        endcase
        n.oe = ~st_r.line.txdis | (n.tx_st != TX_IDLE) | tx_out_valid |
               (send_sw & (~rx_in_ready ^ st_r.xoff_sent));

        // receiver
        n.pv = 1'b0;
        if (st_r.pv && !rx_in_ready) begin
            n.ovr_s = 1'b1;
        end
        if (!recv_sw) begin
            n.hold = 1'b0;
        end
        case (st_r.rx_st)
            RX_IDLE: begin
                if (tick && !rxd) begin
                    n.rx_tk = 4'h0;
                    n.rx_st = RX_START;
                end
            end
            RX_START: begin
                if (tick && st_r.rx_tk == HALF_LAST) begin
                    n.rx_tk  = 4'h0;
                    n.rx_cnt = nb - 4'h1;
                    n.rx_st  = rxd ? RX_IDLE : RX_DATA;
                end else if (tick) begin
                    n.rx_tk = st_r.rx_tk + 4'h1;
                end
            end
            RX_DATA: begin
                if (tick && st_r.rx_tk == TICK_LAST) begin
                    n.rx_tk = 4'h0;
                    n.rx_sh = {rxd, st_r.rx_sh[8:1]};
                    if (st_r.rx_cnt == 4'h0) begin
                        n.rx_st = RX_STOP;
                    end else begin
                        n.rx_cnt = st_r.rx_cnt - 4'h1;
                    end
                end else if (tick) begin
                    n.rx_tk = st_r.rx_tk + 4'h1;
                end
            end
            RX_STOP: begin
                if (tick && st_r.rx_tk == TICK_LAST) begin
                    n.rx_st = RX_IDLE;
                    al   = st_r.rx_sh >> (4'h9 - nb);
                    rd_d = st_r.line.seven ? {1'b0, al[6:0]} : al[7:0];
                    rd_p = st_r.line.seven ? al[7] : al[8];
                    if (!rxd) begin
                        n.ferr_s = 1'b1;
                    end
                    if (st_r.line.par != PAR_NONE &&
                        rd_p != (^rd_d ^ (st_r.line.par == PAR_ODD))) begin
                        n.perr_s = 1'b1;
                    end
                    if (recv_sw && rd_d == XOFF) begin
                        n.hold = 1'b1;
                    end else if (recv_sw && rd_d == XON) begin
                        n.hold = 1'b0;
                    end else begin
                        n.pv = 1'b1;
                        n.pd = rd_d;
                    end
                    if (st_r.line.term_en && rd_d == st_r.line.term) begin
                        n.term_s = 1'b1;
                    end
                end else if (tick) begin
                    n.rx_tk = st_r.rx_tk + 4'h1;
                end
            end
            default: n.rx_st = RX_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            st_r <= ST_RST;
        end else begin
            st_r <= n;
        end
    end
endmodule : csp_top
`default_nettype wire

// ### tb/csp_chk_sva.sv
// pin and bus assertions of the serial port
`timescale 1ns/1ps
`default_nettype none
module csp_chk (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        txd,
    input wire logic        tx_oe
);
    import csp_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire req = wb_cyc_i && wb_stb_i;
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(req))
        else $error("ack without request");
    a_ack_prompt: assert property
        (req && !wb_ack_o && wb_adr_i != ADR_TXD |=> wb_ack_o)
        else $error("ack late");
    a_ack_quiet: assert property (!req |=> !wb_ack_o)
        else $error("ack while idle");
    a_dat_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o))
        else $error("read data moved");
    a_oe_frame: assert property (!txd |-> tx_oe)
        else $error("driver off in frame");
    a_idle_high: assert property (!tx_oe |-> txd)
        else $error("line low while off");
    a_start_len: assert property ($fell(txd) |-> !txd [*8])
        else $error("low bit too short");
    cover property ($rose(wb_ack_o));
    cover property ($fell(txd));
    cover property ($fell(tx_oe));
endmodule : csp_chk
bind csp_top csp_chk u_chk (.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i,
    .wb_adr_i, .wb_dat_o, .wb_ack_o, .txd, .tx_oe);
`default_nettype wire

// ### tb/csp_dev.sv
// serial device model on the far side of the line
`timescale 1ns/1ps
`default_nettype none
module csp_dev (
    input  wire logic clk,
    input  wire logic txd,
    output logic      rxd,
    output logic      cts_n
);
    int         bt = 64;
    logic [8:0] got;
    initial begin
        rxd = 1'b1;
        cts_n = 1'b0;
    end
    task automatic send(input logic [7:0] b);
        rxd <= 1'b0;
        repeat (bt) @(posedge clk);
        for (int i = 0; i < 9; i++) begin
            rxd <= (i < 8) ? b[i] : 1'b1;
            repeat (bt) @(posedge clk);
        end
    endtask : send
    always begin
        @(negedge txd);
        repeat (bt / 2) @(negedge clk);
        for (int i = 0; i < 9; i++) begin
            repeat (bt) @(negedge clk);
            got[i] = txd;
        end
    end
endmodule : csp_dev
`default_nettype wire

// ### tb/csp_tb_top.sv
// self-checking testbench of the serial port
`timescale 1ns/1ps
`default_nettype none
module csp_tb_top;
    import csp_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        cyc     = 1'b0;
    logic        we      = 1'b0;
    logic [7:0]  adr     = 8'h00;
    logic [31:0] wdat    = 32'h0;
    logic [31:0] rdat;
    logic        ack, rxd, cts_n, txd, tx_oe, rts_n;
    int          n_fail  = 0;
    int          checked = 0;
    csp_top #(.CLK_HZ(614400)) DUT (.ref_clk, .rst_n, .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_sel_i(4'hf), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .rxd, .cts_n,
        .txd, .tx_oe, .rts_n);
    csp_dev dev (.clk(ref_clk), .txd, .rxd, .cts_n);
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int i = 0;
        cyc  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge ref_clk);
            i++;
        end while (ack !== 1'b1 && i < 2000);
        q = rdat;
        cyc <= 1'b0;
        if (ack !== 1'b1) begin
            n_fail++;
            print_verdict();
        end
        @(posedge ref_clk);
    endtask : wb
    task automatic cfg(input logic [31:0] v, output logic [31:0] s);
        wb(1'b1, ADR_CFG, v, s);
        wb(1'b1, ADR_CTRL, 32'h1, s);
        repeat (3) @(posedge ref_clk);
        wb(1'b0, ADR_STAT, 32'h0, s);
    endtask : cfg
    task automatic held(input int n);
        int lows = 0;
        repeat (n) begin
            @(posedge ref_clk);
            lows += !txd;
        end
        chk("txd_held", lows, 0);
    endtask : held
    task automatic t_cfg();
        logic [31:0] s;
        logic [31:0] v [9] = '{32'h8, 32'h9, 32'h30, 32'hc0, 32'h300,
            32'h1400, 32'h400, 32'hc00, 32'h1008};
        logic [3:0]  e [9] = '{ERR_RATE, ERR_BAUD, ERR_PARITY, ERR_DBITS,
            ERR_STOP, ERR_FLOW, ERR_NONE, ERR_NONE, ERR_NONE};
        for (int k = 0; k < 9; k++) begin
            cfg(v[k], s);
            chk("stat_err", s[11:8], e[k]);
            chk("stat_flag", s[1:0], e[k] == 0 ? 2'h1 : 2'h2);
        end
        for (int b = 1; b < 8; b++) begin
            cfg(b, s);
            chk("rate_ok", s[11:8], ERR_NONE);
        end
    endtask : t_cfg
    task automatic t_tx();
        logic [31:0] s;
        logic [31:0] c [3] = '{32'h0, 32'h50, 32'h60};
        logic [8:0]  x [3] = '{9'h155, 9'h187, 9'h107};
        for (int k = 0; k < 3; k++) begin
            cfg(c[k], s);
            wb(1'b1, ADR_TXD, k ? 32'h07 : 32'h55, s);
            repeat (760) @(posedge ref_clk);
            chk("tx_frame", dev.got, x[k]);
        end
    endtask : t_tx
    task automatic t_rx();
        logic [31:0] s;
        cfg(32'h6e000, s);
        dev.send(8'h0d);
        wb(1'b0, ADR_RXD, 32'h0, s);
        chk("rx_byte", s[8:0], 9'h10d);
        wb(1'b0, ADR_STAT, 32'h0, s);
        chk("term_seen", s[STAT_TERM], 1'b1);
        chk("oe_off", tx_oe, 1'b0);
    endtask : t_rx
    task automatic t_xoff();
        logic [31:0] s;
        cfg(32'h800, s);
        dev.send(XOFF);
        wb(1'b1, ADR_TXD, 32'h3c, s);
        held(760);
        wb(1'b0, ADR_STAT, 32'h0, s);
        chk("hold_flag", s[STAT_HOLD], 1'b1);
        dev.send(XON);
        repeat (760) @(posedge ref_clk);
        chk("resumed", dev.got, 9'h13c);
    endtask : t_xoff
    task automatic t_soft();
        logic [31:0] s;
        cfg(32'h400, s);
        dev.send(8'h41);
        dev.send(8'h42);
        repeat (700) @(posedge ref_clk);
        chk("xoff_sent", dev.got, 9'h113);
        wb(1'b0, ADR_RXD, 32'h0, s);
        wb(1'b0, ADR_RXD, 32'h0, s);
        chk("rx_second", s[8:0], 9'h142);
        repeat (760) @(posedge ref_clk);
        chk("xon_sent", dev.got, 9'h111);
    endtask : t_soft
    task automatic t_hw();
        logic [31:0] s;
        cfg(32'h1008, s);
        dev.bt = 32;
        dev.cts_n <= 1'b1;
        wb(1'b1, ADR_TXD, 32'ha5, s);
        held(400);
        dev.cts_n <= 1'b0;
        repeat (400) @(posedge ref_clk);
        chk("hw_sent", dev.got, 9'h1a5);
        dev.send(8'h01);
        dev.send(8'h02);
        chk("rts_full", rts_n, 1'b1);
    endtask : t_hw
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        t_cfg();
        t_tx();
        t_rx();
        t_xoff();
        t_soft();
        t_hw();
        print_verdict();
    end
endmodule : csp_tb_top
`default_nettype wire
